// ### rtl/asq_core.sv
// What this block does
// - The first conversion command after idle inserts a power-up wait; a zero setting skips it.
// - Power-up wait is the 5-bit field times two microseconds.
// - Acquisition is the 5-bit field times 2 us plus 6 us.
// - Conversion always lasts four microseconds.
// - Sleep modes wait a programmed time; x8 and /4 bits scale it.
// - Interrupt pin source: busy, data ready or alarm.
// - Reading the interrupt configuration register clears alarm interrupt.
// - Reading a low result byte clears the data-ready interrupt.
// - Interrupt pin is a level or a 250 ns pulse.
// - Results are 12-bit straight binary, clamped at 0h and FFFh.
// - Per-channel 8-bit window trips at or beyond either limit.
// - Per-channel trip counter raises an alarm at the threshold.
// - Alarm channel is readable; interrupt register read clears it all.
// - A mode write takes effect as soon as it completes.
// - Idle shuts everything down; awake keeps the analog section running but not the amplifier.
// - Amplifier power output follows the conversion cycle as configured.
// - Multiplexer output can be tied to analog ground.
// - Each result lands in its own channel register, no latency.
// - Address pin picks one of two bus addresses; standard and fast.
// - Manual-single converts once; power-up only on first command.
// - Scan modes advance the channel, wrapping three to zero.
`timescale 1ns/1ps
`include "asq_defs.svh"

module asq_core #(
  parameter int TICK_CYC = `ASQ_TICK_CYC,
  parameter int SLP_UNIT_TK = `ASQ_SLP_UNIT_TK,
  parameter int PULSE_CYC = `ASQ_PULSE_CYC
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addrSelectPin,
  input wire logic signed [13:0] sarCode,
  output logic [1:0] muxSel,
  output logic muxGroundOut,
  output logic acqOut,
  output logic convOut,
  output logic analogOnOut,
  output logic intOut,
  output logic ampPowerCtrlOut
);
  typedef struct packed {
    asq_pkg::asq_mode_e mode;
    logic [1:0] chSel;
    logic [3:0] cmpEn;
    logic [3:0] alarm;
    logic [3:0][11:0] data;
    logic [3:0][7:0] upper;
    logic [3:0][7:0] lower;
    logic [3:0][2:0] trips;
    logic [7:0] intCfg;
    logic [7:0] sleepCfg;
    logic [7:0] pwrCfg;
    logic [4:0] acqCfg;
    logic [4:0] puCfg;
    asq_pkg::asq_seq_e seq;
    logic [7:0] pre;
    logic [15:0] timer;
    logic [1:0] ch;
    logic [2:0] left;
    logic poweredUp;
    logic dataRdy;
    logic condD;
    logic [4:0] pulseCnt;
    logic intOut;
    logic ampOut;
    logic muxGnd;
    logic acqOut;
    logic convOut;
    logic analogOn;
    logic [1:0] muxSel;
  } asq_core_s;

  localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);
  localparam logic [4:0] PULSE_LD = 5'(PULSE_CYC);
  localparam logic [15:0] SLP_UNIT = 16'(SLP_UNIT_TK);

  if (TICK_CYC < 2 || TICK_CYC > 256 || PULSE_CYC < 1 ||
      PULSE_CYC > 31 || SLP_UNIT_TK < 1 || SLP_UNIT_TK > 500) begin : g_chk
    $error("asq_core: parameter out of range");
  end

  asq_core_s q;
  asq_core_s n;
  asq_pkg::asq_bus_s bus;
  logic [7:0] ptr;
  logic [7:0] rdData;
  logic tick;
  logic timed;
  logic phaseLoad;
  logic convDone;
  logic almHit;
  logic modeWr;
  logic goAcq;
  logic goSleep;
  logic cond;
  logic busy;
  logic ampOn;
  logic [11:0] res;
  logic [15:0] sleepTk;
  logic [15:0] acqTk;
  logic [3:0] tripCnt;

  // Serial register access
  asq_i2c_slave u_i2c (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .addrSelectPin(addrSelectPin),
    .rdData(rdData),
    .sdaOe(sdaOe),
    .ptr(ptr),
    .bus(bus)
  );

  // Out-of-range converter codes clip to the rails
  function automatic logic [11:0] clamp12(input logic signed [13:0] v);
    if (v < 0) return `ASQ_CODE_MIN;
    if (v > $signed({2'b00, `ASQ_CODE_MAX})) return `ASQ_CODE_MAX;
    return v[11:0];
  endfunction

  assign modeWr = bus.wr && bus.addr == `ASQ_REG_MODE;

  // Register file, sequencer, comparators and interrupt pin
  always_comb begin
    n = q;
    rdData = 8'h00;
    phaseLoad = 1'b0;
    convDone = 1'b0;
    almHit = 1'b0;
    goAcq = 1'b0;
    goSleep = 1'b0;
    tripCnt = 4'h0;
    res = clamp12(sarCode);
    tick = q.pre == TICK_LAST;
    n.pre = tick ? 8'h00 : q.pre + 8'h01;
    acqTk = 16'(q.acqCfg) + `ASQ_ACQ_MIN_TK;
    sleepTk = (16'(q.sleepCfg[`ASQ_SLP_F]) + 16'h0001) * SLP_UNIT;
    if (q.sleepCfg[`ASQ_SLP_X8_B]) sleepTk = sleepTk << 3;
    if (q.sleepCfg[`ASQ_SLP_D4_B]) sleepTk = sleepTk >> 2;
    if (sleepTk == 16'h0000) sleepTk = 16'h0001;

    // Read data mux
    case (ptr)
      `ASQ_REG_MODE: begin
        rdData[`ASQ_MODE_F] = q.mode;
        rdData[`ASQ_CH_F] = q.chSel;
      end
      `ASQ_REG_ALM: begin
        rdData[`ASQ_ALM_ST_F] = q.alarm;
        rdData[`ASQ_ALM_EN_F] = q.cmpEn;
      end
      `ASQ_REG_INTCFG: rdData = q.intCfg;
      `ASQ_REG_SLP: rdData = q.sleepCfg;
      `ASQ_REG_ACQ: rdData[`ASQ_TIME_F] = q.acqCfg;
      `ASQ_REG_PU: rdData[`ASQ_TIME_F] = q.puCfg;
      `ASQ_REG_PWR: rdData = q.pwrCfg;
      default: rdData = 8'h00;
    endcase
    for (int i = 0; i < 4; i++) begin
      if (ptr == `ASQ_REG_DATA0 + 8'(2 * i))
        rdData = q.data[i][`ASQ_HI_F];
      if (ptr == `ASQ_REG_DATA0 + 8'(2 * i + 1))
        rdData = {q.data[i][`ASQ_LO_F], 4'h0};
      if (ptr == `ASQ_REG_LIMIT0 + 8'(2 * i))
        rdData = q.upper[i];
      if (ptr == `ASQ_REG_LIMIT0 + 8'(2 * i + 1))
        rdData = q.lower[i];
    end

    // Read side effects, applied before any new event sets
    if (bus.rd && bus.addr == `ASQ_REG_INTCFG) begin
      n.alarm = 4'h0;
      n.trips = '0;
    end
    for (int i = 0; i < 4; i++) begin
      if (bus.rd && bus.addr == `ASQ_REG_DATA0 + 8'(2 * i + 1))
        n.dataRdy = 1'b0;
    end

    // Configuration writes
    if (bus.wr) begin
      case (bus.addr)
        `ASQ_REG_ALM: n.cmpEn = bus.wdata[`ASQ_ALM_EN_F];
        `ASQ_REG_INTCFG: n.intCfg = bus.wdata;
        `ASQ_REG_SLP: n.sleepCfg = bus.wdata;
        `ASQ_REG_ACQ: n.acqCfg = bus.wdata[`ASQ_TIME_F];
        `ASQ_REG_PU: n.puCfg = bus.wdata[`ASQ_TIME_F];
        `ASQ_REG_PWR: n.pwrCfg = bus.wdata;
        default: n.pwrCfg = q.pwrCfg;
      endcase
      for (int i = 0; i < 4; i++) begin
        if (bus.addr == `ASQ_REG_LIMIT0 + 8'(2 * i))
          n.upper[i] = bus.wdata;
        if (bus.addr == `ASQ_REG_LIMIT0 + 8'(2 * i + 1))
          n.lower[i] = bus.wdata;
      end
    end

    // Phase timer in two-microsecond ticks
    timed = q.seq inside {asq_pkg::SQ_PWRUP, asq_pkg::SQ_ACQ,
                          asq_pkg::SQ_CONV, asq_pkg::SQ_SLEEP};
    if (timed && tick && q.timer != 16'h0001)
      n.timer = q.timer - 16'h0001;
    if (timed && tick && q.timer == 16'h0001) begin
      unique case (q.seq)
        asq_pkg::SQ_PWRUP: goAcq = 1'b1;
        asq_pkg::SQ_ACQ: begin
          n.seq = asq_pkg::SQ_CONV;
          n.timer = `ASQ_CONV_TK;
          phaseLoad = 1'b1;
        end
        asq_pkg::SQ_SLEEP: begin
          n.left = `ASQ_NCH;
          goAcq = 1'b1;
        end
        asq_pkg::SQ_CONV: begin
          convDone = 1'b1;
          n.data[q.ch] = res;
          n.dataRdy = 1'b1;
          // Window compare on the upper eight result bits
          if (q.cmpEn[q.ch] && (res[`ASQ_HI_F] <= q.lower[q.ch] ||
              res[`ASQ_HI_F] >= q.upper[q.ch])) begin
            tripCnt = {1'b0, n.trips[q.ch]} + 4'h1;
            n.trips[q.ch] = (n.trips[q.ch] == `ASQ_TRIP_MAX) ?
                            `ASQ_TRIP_MAX : tripCnt[2:0];
            if (tripCnt >= {1'b0, q.intCfg[`ASQ_THR_F]}) begin
              n.alarm[q.ch] = 1'b1;
              almHit = 1'b1;
            end
          end
          n.left = q.left - 3'h1;
          if (q.mode inside {asq_pkg::MD_MSCAN, asq_pkg::MD_ASCAN,
              asq_pkg::MD_ASCAN_SLP, asq_pkg::MD_BURST})
            n.ch = q.ch + 2'h1;
          unique case (q.mode)
            asq_pkg::MD_MSCAN: begin
              if (q.left == 3'h1) n.seq = asq_pkg::SQ_AWAKE;
              else goAcq = 1'b1;
            end
            asq_pkg::MD_ASINGLE, asq_pkg::MD_ASCAN: goAcq = 1'b1;
            asq_pkg::MD_ASINGLE_SLP, asq_pkg::MD_ASCAN_SLP:
              goSleep = 1'b1;
            asq_pkg::MD_BURST: begin
              if (q.left == 3'h1) goSleep = 1'b1;
              else goAcq = 1'b1;
            end
            default: n.seq = asq_pkg::SQ_AWAKE;
          endcase
        end
        default: n.seq = asq_pkg::SQ_OFF;
      endcase
    end

    // Mode write restarts the sequencer at once
    if (modeWr) begin
      goAcq = 1'b0;
      goSleep = 1'b0;
      n.mode = asq_pkg::asq_mode_e'(bus.wdata[`ASQ_MODE_F]);
      n.chSel = bus.wdata[`ASQ_CH_F];
      n.ch = bus.wdata[`ASQ_CH_F];
      n.left = `ASQ_NCH;
      if (n.mode == asq_pkg::MD_IDLE) begin
        n.seq = asq_pkg::SQ_OFF;
        n.poweredUp = 1'b0;
      end else if (n.mode == asq_pkg::MD_AWAKE ||
                   n.mode > asq_pkg::MD_BURST) begin
        // Power-up stays pending so the first conversion pays for it
        n.seq = asq_pkg::SQ_AWAKE;
      end else begin
        n.poweredUp = 1'b1;
        if (!q.poweredUp && q.puCfg != 5'h00) begin
          n.seq = asq_pkg::SQ_PWRUP;
          n.timer = 16'(q.puCfg);
          phaseLoad = 1'b1;
        end else begin
          goAcq = 1'b1;
        end
      end
    end
    if (goAcq) begin
      n.seq = asq_pkg::SQ_ACQ;
      n.timer = acqTk;
      phaseLoad = 1'b1;
    end
    if (goSleep) begin
      n.seq = asq_pkg::SQ_SLEEP;
      n.timer = sleepTk;
      phaseLoad = 1'b1;
    end
    if (phaseLoad) n.pre = 8'h00;

    // Interrupt source and pin shape
    busy = n.seq inside {asq_pkg::SQ_ACQ, asq_pkg::SQ_CONV};
    case (q.intCfg[`ASQ_SRC_F])
      `ASQ_SRC_ALARM: cond = |n.alarm;
      `ASQ_SRC_BUSY: cond = busy;
      `ASQ_SRC_READY: cond = n.dataRdy;
      default: cond = (|n.alarm) | n.dataRdy;
    endcase
    n.condD = cond;
    if (q.intCfg[`ASQ_PULSE_B]) begin
      if (cond && !q.condD && q.pulseCnt == 5'h00)
        n.pulseCnt = PULSE_LD;
      else if (q.pulseCnt != 5'h00)
        n.pulseCnt = q.pulseCnt - 5'h01;
      n.intOut = n.pulseCnt != 5'h00;
    end else begin
      n.pulseCnt = 5'h00;
      n.intOut = cond;
    end

    // Analog side controls
    ampOn = n.seq inside {asq_pkg::SQ_PWRUP, asq_pkg::SQ_ACQ,
                          asq_pkg::SQ_CONV};
    n.ampOut = n.pwrCfg[`ASQ_AMP_EN_B] &
               (ampOn == n.pwrCfg[`ASQ_AMP_POL_B]);
    n.muxGnd = n.pwrCfg[`ASQ_MUXGND_B];
    n.acqOut = n.seq == asq_pkg::SQ_ACQ;
    n.convOut = n.seq == asq_pkg::SQ_CONV;
    n.analogOn = n.seq != asq_pkg::SQ_OFF;
    n.muxSel = n.ch;
  end

  // Single state register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) q <= '0;
    else q <= n;
  end

  assign sdaOut = 1'b0;
  assign muxSel = q.muxSel;
  assign muxGroundOut = q.muxGnd;
  assign acqOut = q.acqOut;
  assign convOut = q.convOut;
  assign analogOnOut = q.analogOn;
  assign intOut = q.intOut;
  assign ampPowerCtrlOut = q.ampOut;

  // Cycles since the last phase load, for checks only
  logic [15:0] phaseLen;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) phaseLen <= 16'h0000;
    else if (phaseLoad) phaseLen <= 16'h0000;
    else phaseLen <= phaseLen + 16'h0001;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  conv_time_a: assert property (
    q.seq == asq_pkg::SQ_CONV && tick && q.timer == 16'h0001 |->
      int'(phaseLen) == 2 * TICK_CYC - 1)
    else $error("conversion phase length wrong");

  acq_time_a: assert property (
    q.seq == asq_pkg::SQ_ACQ && tick && q.timer == 16'h0001 |->
      int'(phaseLen) == (int'(q.acqCfg) + 3) * TICK_CYC - 1)
    else $error("acquisition phase length wrong");

  pu_time_a: assert property (
    q.seq == asq_pkg::SQ_PWRUP && tick && q.timer == 16'h0001 |->
      int'(phaseLen) == int'(q.puCfg) * TICK_CYC - 1)
    else $error("power-up phase length wrong");

  pu_skip_a: assert property (
    modeWr && q.puCfg == 5'h00 &&
    bus.wdata[`ASQ_MODE_F] inside {[4'h2:4'h8]} |=>
      q.seq == asq_pkg::SQ_ACQ)
    else $error("zero power-up did not skip");

  alarm_set_a: assert property (
    convDone && almHit |=> q.alarm[$past(q.ch)])
    else $error("alarm not raised at threshold");

  alarm_clr_a: assert property (
    bus.rd && bus.addr == `ASQ_REG_INTCFG && !convDone |=>
      q.alarm == 4'h0 && q.trips == '0)
    else $error("alarm read did not clear");

  rdy_clr_a: assert property (
    bus.rd && bus.addr == `ASQ_REG_DATA0 + 8'h01 && !convDone |=>
      !q.dataRdy)
    else $error("low byte read did not clear ready");

  sat_high_a: assert property (
    convDone && sarCode > 14'sh0fff |=>
      q.data[$past(q.ch)] == `ASQ_CODE_MAX)
    else $error("result not clipped at full scale");

  pulse_len_a: assert property (
    $rose(q.intOut) && q.intCfg[`ASQ_PULSE_B] &&
    $stable(q.intCfg) |-> ##24 q.intOut ##1 !q.intOut)
    else $error("interrupt pulse width wrong");

  idle_off_a: assert property (
    modeWr && bus.wdata[`ASQ_MODE_F] == 4'h0 |=> !q.analogOn ##1
      !q.analogOn)
    else $error("idle did not shut down");
endmodule

// ### rtl/asq_defs.svh
`ifndef ASQ_DEFS_SVH
`define ASQ_DEFS_SVH

// Timing base and fixed phases
`define ASQ_CLK_NS 10
`define ASQ_BASE_NS 2000
`define ASQ_TICK_CYC (`ASQ_BASE_NS / `ASQ_CLK_NS)
`define ASQ_ACQ_MIN_US 6
`define ASQ_ACQ_MIN_TK 16'((`ASQ_ACQ_MIN_US * 1000) / `ASQ_BASE_NS)
`define ASQ_CONV_US 4
`define ASQ_CONV_TK 16'((`ASQ_CONV_US * 1000) / `ASQ_BASE_NS)
`define ASQ_PULSE_NS 250
`define ASQ_PULSE_CYC (`ASQ_PULSE_NS / `ASQ_CLK_NS)
`define ASQ_SLP_UNIT_TK 500

// Serial address, upper six bits
`define ASQ_I2C_BASE 6'h24

// Register offsets
`define ASQ_REG_MODE 8'h00
`define ASQ_REG_ALM 8'h01
`define ASQ_REG_DATA0 8'h02
`define ASQ_REG_LIMIT0 8'h0a
`define ASQ_REG_INTCFG 8'h12
`define ASQ_REG_SLP 8'h13
`define ASQ_REG_ACQ 8'h14
`define ASQ_REG_PU 8'h15
`define ASQ_REG_PWR 8'h16

// Field positions
`define ASQ_MODE_F 7:4
`define ASQ_CH_F 1:0
`define ASQ_ALM_ST_F 7:4
`define ASQ_ALM_EN_F 3:0
`define ASQ_THR_F 7:5
`define ASQ_SRC_F 3:2
`define ASQ_PULSE_B 1
`define ASQ_SLP_F 2:0
`define ASQ_SLP_X8_B 5
`define ASQ_SLP_D4_B 6
`define ASQ_TIME_F 4:0
`define ASQ_AMP_EN_B 7
`define ASQ_AMP_POL_B 6
`define ASQ_MUXGND_B 5
`define ASQ_HI_F 11:4
`define ASQ_LO_F 3:0

// Interrupt sources
`define ASQ_SRC_ALARM 2'h0
`define ASQ_SRC_BUSY 2'h1
`define ASQ_SRC_READY 2'h2

// Codes and counts
`define ASQ_CODE_MAX 12'hfff
`define ASQ_CODE_MIN 12'h000
`define ASQ_NCH 3'h4
`define ASQ_TRIP_MAX 3'h7

`endif

// ### rtl/asq_i2c_slave.sv
`timescale 1ns/1ps
`include "asq_defs.svh"

module asq_i2c_slave (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic addrSelectPin,
  input wire logic [7:0] rdData,
  output logic sdaOe,
  output logic [7:0] ptr,
  output asq_pkg::asq_bus_s bus
);
  asq_pkg::asq_i2c_s q;
  asq_pkg::asq_i2c_s n;
  logic sclRise;
  logic sclFall;
  logic start;
  logic stop;

  // Byte engine on filtered bus levels
  always_comb begin
    n = q;
    n.bus.wr = 1'b0;
    n.bus.rd = 1'b0;
    n.scl = {q.scl[1:0], sclIn};
    n.sda = {q.sda[1:0], sdaIn};
    n.sel = {q.sel[1:0], addrSelectPin};
    if (q.scl[1] == q.scl[2]) n.sclF = q.scl[2];
    if (q.sda[1] == q.sda[2]) n.sdaF = q.sda[2];
    if (q.sel[1] == q.sel[2]) n.selF = q.sel[2];
    sclRise = n.sclF & ~q.sclF;
    sclFall = ~n.sclF & q.sclF;
    start = q.sclF & n.sclF & q.sdaF & ~n.sdaF;
    stop = q.sclF & n.sclF & ~q.sdaF & n.sdaF;
    if (start) begin
      n.st = asq_pkg::IC_ADDR;
      n.cnt = 4'h0;
      n.gotPtr = 1'b0;
      n.sdaOe = 1'b0;
    end else if (stop) begin
      n.st = asq_pkg::IC_IDLE;
      n.sdaOe = 1'b0;
    end else begin
      unique case (q.st)
        asq_pkg::IC_IDLE: begin
        end
        asq_pkg::IC_ADDR, asq_pkg::IC_WR: begin
          if (sclRise) begin
            n.sh = {q.sh[6:0], n.sdaF};
            n.cnt = q.cnt + 4'h1;
          end else if (sclFall && q.cnt == 4'h8) begin
            n.st = asq_pkg::IC_ACK;
            n.sdaOe = 1'b1;
            if (q.st == asq_pkg::IC_ADDR) begin
              n.rnw = q.sh[0];
              // Address pin picks one of two addresses
              if (q.sh[7:1] != {`ASQ_I2C_BASE, q.selF}) begin
                n.st = asq_pkg::IC_IDLE;
                n.sdaOe = 1'b0;
              end
            end else if (!q.gotPtr) begin
              n.ptr = q.sh;
              n.gotPtr = 1'b1;
            end else begin
              n.bus.wr = 1'b1;
              n.bus.addr = q.ptr;
              n.bus.wdata = q.sh;
              n.ptr = q.ptr + 8'h01;
            end
          end
        end
        asq_pkg::IC_ACK: begin
          if (sclFall) begin
            n.cnt = 4'h0;
            if (q.rnw) begin
              n.sh = rdData;
              n.sdaOe = ~rdData[7];
              n.bus.rd = 1'b1;
              n.bus.addr = q.ptr;
              n.ptr = q.ptr + 8'h01;
              n.st = asq_pkg::IC_RD;
            end else begin
              n.sdaOe = 1'b0;
              n.st = asq_pkg::IC_WR;
            end
          end
        end
        asq_pkg::IC_RD: begin
          if (sclFall) begin
            if (q.cnt == 4'h7) begin
              n.sdaOe = 1'b0;
              n.st = asq_pkg::IC_ACKR;
            end else begin
              n.cnt = q.cnt + 4'h1;
              n.sh = {q.sh[6:0], 1'b0};
              n.sdaOe = ~q.sh[6];
            end
          end
        end
        asq_pkg::IC_ACKR: begin
          if (sclRise) begin
            n.st = n.sdaF ? asq_pkg::IC_IDLE : asq_pkg::IC_ACK;
          end
        end
        default: n.st = asq_pkg::IC_IDLE;
      endcase
    end
  end

  // State register, bus idles high
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.scl <= 3'h7;
      q.sda <= 3'h7;
      q.sclF <= 1'b1;
      q.sdaF <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign sdaOe = q.sdaOe;
  assign ptr = q.ptr;
  assign bus = q.bus;
endmodule

// ### rtl/asq_pkg.sv
package asq_pkg;

  typedef enum logic [3:0] {
    MD_IDLE, MD_AWAKE, MD_MSINGLE, MD_MSCAN, MD_ASINGLE,
    MD_ASCAN, MD_ASINGLE_SLP, MD_ASCAN_SLP, MD_BURST
  } asq_mode_e;

  typedef enum logic [2:0] {
    SQ_OFF, SQ_AWAKE, SQ_PWRUP, SQ_ACQ, SQ_CONV, SQ_SLEEP
  } asq_seq_e;

  typedef enum logic [2:0] {
    IC_IDLE, IC_ADDR, IC_WR, IC_ACK, IC_RD, IC_ACKR
  } asq_i2c_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } asq_bus_s;

  typedef struct packed {
    logic [2:0] scl;
    logic [2:0] sda;
    logic [2:0] sel;
    logic sclF;
    logic sdaF;
    logic selF;
    asq_i2c_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic gotPtr;
    logic rnw;
    logic sdaOe;
    asq_bus_s bus;
  } asq_i2c_s;

endpackage

// ### sim/asq_core_tb.sv
`timescale 1ns/1ps

module asq_core_tb;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic addrSel = 1'b0;
  logic signed [13:0] sarCode = 14'sh0;
  logic sdaOut, sdaOe, muxGroundOut, acqOut, convOut, analogOnOut;
  logic intOut, amp, scl, sdaLow, ampSeen;
  logic [1:0] muxSel, chSeen;
  logic [7:0] rx, a;
  logic [1:0] ch;
  logic [11:0] ex;
  int bad_count = 0;
  int n_tests = 0;
  int nacks, la, lc, lp, lw, pw;
  wire sdaWire = ~sdaLow & (sdaOe ? sdaOut : 1'b1);

  always #5 ref_clk = ~ref_clk;

  asq_core #(.TICK_CYC(4), .SLP_UNIT_TK(1), .PULSE_CYC(25)) i_dut (
    .ref_clk(ref_clk), .rstn(rstn), .sclIn(scl), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelectPin(addrSel),
    .sarCode(sarCode), .muxSel(muxSel), .muxGroundOut(muxGroundOut),
    .acqOut(acqOut), .convOut(convOut), .analogOnOut(analogOnOut),
    .intOut(intOut), .ampPowerCtrlOut(amp)
  );

  asq_host_model i_host (
    .ref_clk(ref_clk), .sdaWire(sdaWire), .sel(addrSel), .scl(scl),
    .sdaLow(sdaLow), .nacks(nacks)
  );

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Expected stored code for a raw converter value
  function automatic logic [11:0] clampc(logic signed [13:0] c);
    if (c < 0) return 12'h000;
    if (c > 14'sh0fff) return 12'hfff;
    return c[11:0];
  endfunction

  // Expected sleep span in cycles, bench tick of four cycles
  function automatic logic [15:0] slp_cyc(logic [7:0] c);
    int t;
    t = c[2:0] + 1;
    if (c[5]) t = t * 8;
    if (c[6]) t = t / 4;
    if (t == 0) t = 1;
    return 16'(t * 4);
  endfunction

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Phase lengths seen on settled outputs at falling edges
  task automatic phases();
    la = 0;
    lc = 0;
    lp = 0;
    for (lw = 0; lw < 3000 && acqOut !== 1'b1; lw++) begin
      @(negedge ref_clk);
      if (amp === 1'b1 && acqOut !== 1'b1) lp++;
    end
    chSeen = muxSel;
    ampSeen = amp;
    while (acqOut === 1'b1 && la < 3000) begin
      @(negedge ref_clk);
      la++;
    end
    while (convOut === 1'b1 && lc < 3000) begin
      @(negedge ref_clk);
      lc++;
    end
  endtask

  initial begin
    repeat (60000) @(posedge ref_clk);
    bad_count++;
    stop_test();
  end

  initial begin
    void'($urandom(88635));
    repeat (8) @(posedge ref_clk);
    addrSel <= 1'($urandom());
    rstn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    check("analog on idle", analogOnOut, 1'b0);
    i_host.wr(8'h00, 8'h10);
    @(negedge ref_clk);
    check("analog on awake", analogOnOut, 1'b1);
    i_host.rd(8'h20, rx);
    check("unmapped read", rx, 8'h00);
    i_host.wr(8'h16, 8'he0);
    @(negedge ref_clk);
    check("mux ground", muxGroundOut, 1'b1);
    i_host.wr(8'h12, 8'h08);
    $display("setup test done");
    for (int t = 0; t < 5; t++) begin
      a = (t == 0) ? 8'h00 : (t == 1) ? 8'h1f : 8'($urandom_range(31));
      ch = 2'($urandom());
      sarCode <= (t == 0) ? -14'sd5 : (t == 1) ? 14'sh1fff :
        14'($urandom_range(4095));
      i_host.wr(8'h14, a);
      i_host.rd(8'h14, rx);
      check("acquire field", rx, a);
      fork
        i_host.wr(8'h00, {4'h2, 2'b00, ch});
        phases();
      join
      ex = clampc(sarCode);
      check("acquire length", 16'(la), 16'((a + 3) * 4));
      check("convert length", 16'(lc), 16'h0008);
      check("channel", chSeen, ch);
      check("no power-up", 16'(lp), 16'h0000);
      check("amp power", ampSeen, 1'b1);
      check("ready int", intOut, 1'b1);
      i_host.rd(8'h02 + 8'(2 * ch), rx);
      check("result high", rx, ex[11:4]);
      check("int kept", intOut, 1'b1);
      i_host.rd(8'h03 + 8'(2 * ch), rx);
      check("result low", rx, {ex[3:0], 4'h0});
      check("int cleared", intOut, 1'b0);
      $display("conversion test %0d done", t);
    end
    i_host.wr(8'h00, 8'h00);
    @(negedge ref_clk);
    check("analog off", analogOnOut, 1'b0);
    a = 8'($urandom_range(31, 1));
    i_host.wr(8'h15, a);
    i_host.wr(8'h00, 8'h10);
    fork
      i_host.wr(8'h00, {4'h2, 2'h0, ch});
      phases();
    join
    check("power-up length", 16'(lp), 16'(a * 4));
    $display("power-up test done");
    i_host.wr(8'h00, 8'h10);
    fork
      i_host.wr(8'h00, {4'h3, 2'h0, ch});
      phases();
    join
    for (int k = 0; k < 4; k++) begin
      check("scan channel", chSeen, ch);
      ch = ch + 2'h1;
      phases();
    end
    check("scan stops", 16'(la), 16'h0000);
    $display("scan test done");
    i_host.wr(8'h00, 8'h10);
    i_host.wr(8'h14, 8'h1f);
    i_host.wr(8'h01, 8'h0f);
    i_host.wr(8'h0a + 8'(2 * ch), 8'hc0);
    i_host.wr(8'h0b + 8'(2 * ch), 8'h40);
    i_host.wr(8'h12, 8'h42);
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk);
      sarCode <= (k == 0) ? 14'sh0c00 : (k == 1) ? 14'sh0800 : 14'sh040f;
      fork
        i_host.wr(8'h00, {4'h2, 2'h0, ch});
        phases();
      join
      check("power-up once", 16'(lp), 16'h0000);
      if (k < 2) begin
        check("alarm early", intOut, 1'b0);
      end else begin
        pw = 0;
        while (intOut === 1'b1 && pw < 100) begin
          @(negedge ref_clk);
          pw++;
        end
        check("pulse width", 16'(pw), 16'h0019);
      end
    end
    i_host.rd(8'h01, rx);
    check("alarm status", rx, {4'h1 << ch, 4'hf});
    i_host.rd(8'h12, rx);
    check("int config", rx, 8'h42);
    i_host.rd(8'h01, rx);
    check("alarm cleared", rx, 8'h0f);
    $display("alarm test done");
    i_host.wr(8'h00, 8'h10);
    a = 8'($urandom()) & 8'h67;
    i_host.wr(8'h13, a);
    fork
      i_host.wr(8'h00, {4'h6 + 4'($urandom_range(1)), 2'h0, ch});
      phases();
    join
    phases();
    check("sleep length", 16'(lw), slp_cyc(a));
    check("acquire again", 16'(la), 16'h0088);
    i_host.wr(8'h00, 8'h10);
    $display("sleep test done");
    check("device acks", 16'(nacks), 16'h0000);
    stop_test();
  end
endmodule

// ### sim/asq_host_model.sv
`timescale 1ns/1ps
`include "asq_defs.svh"

// Two-wire bus host; its clock stands high between frames
module asq_host_model (
  input wire logic ref_clk,
  input wire logic sdaWire,
  input wire logic sel,
  output logic scl,
  output logic sdaLow,
  output int nacks
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
    nacks = 0;
  end

  task automatic wt(int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // One bit: 8 cycles low, 8 high, line sampled at end of high
  task automatic bit1(logic b, output logic r);
    wt(4);
    sdaLow <= ~b;
    wt(4);
    scl <= 1'b1;
    wt(8);
    r = sdaWire;
    scl <= 1'b0;
  endtask

  // Byte plus ninth bit, released by host; chk expects device ack
  task automatic xfer(logic [7:0] tx, logic chk, output logic [7:0] rx);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit1(tx[i], rx[i]);
    end
    bit1(1'b1, a);
    if (chk && a !== 1'b0) nacks++;
  endtask

  // Start and stop edges of data while clock high
  task automatic start();
    sdaLow <= 1'b1;
    wt(8);
    scl <= 1'b0;
  endtask

  task automatic stop();
    wt(4);
    sdaLow <= 1'b1;
    wt(4);
    scl <= 1'b1;
    wt(8);
    sdaLow <= 1'b0;
    wt(8);
  endtask

  // Register write: address, pointer, data
  task automatic wr(logic [7:0] r, logic [7:0] d);
    logic [7:0] x;
    start();
    xfer({`ASQ_I2C_BASE, sel, 1'b0}, 1'b1, x);
    xfer(r, 1'b1, x);
    xfer(d, 1'b1, x);
    stop();
  endtask

  // Register read: set pointer, then one byte ended by nack
  task automatic rd(logic [7:0] r, output logic [7:0] d);
    logic [7:0] x;
    start();
    xfer({`ASQ_I2C_BASE, sel, 1'b0}, 1'b1, x);
    xfer(r, 1'b1, x);
    stop();
    start();
    xfer({`ASQ_I2C_BASE, sel, 1'b1}, 1'b1, x);
    xfer(8'hff, 1'b0, d);
    stop();
  endtask
endmodule
